// ### sfcs_top.sv
`timescale 1ns/1ps
`include "sfcs_consts.svh"

////////////////////////////////////////////////////////////////////////
// FIFO of 16-bit offset and data byte entries between the serial front end and the page buffer
module sfcs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [WIDTH-1:0] store [0:DEPTH-1];

    // Full and empty from pointer distance
    assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign out_data = store[rd_reg[AW-1:0]];

    // Pointer advance
    always_comb
    begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (in_valid && in_ready)
            wr_next = wr_reg + 1'b1;
        if (out_valid && out_ready)
            rd_next = rd_reg + 1'b1;
    end

    // Pointer registers
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // Storage write
    always_ff @(posedge clock)
    begin
        if (in_valid && in_ready)
            store[wr_reg[AW-1:0]] <= in_data;
    end
endmodule : sfcs_fifo

////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Chip erase is the lone opcode C7h, one bus cycle, no address.
// [RULE2] Erase starts at chip select rise, timer ends it, busy shows it.
// [RULE3] Chip erase sets every cell of the array to all ones.
// [RULE4] Page program writes 1 to 256 bytes inside one page, A17..A8.
// [RULE5] Program opcode 92h then 24-bit address; low byte is start offset.
// [RULE6] Program data is taken on rising clock until chip select rises.
// [RULE7] Beyond 256 data bytes only the last 256 are programmed.
// [RULE8] Program runs only if chip select rises on a byte boundary.
// [RULE9] Host erases the target page before programming it.
// [RULE10] Full page program holds busy for about 2.0 ms.
// [RULE11] Both identity reads are ignored while a write is running.
// [RULE12] After 9Fh: maker, type, capacity, reserved, repeated endlessly.
// [RULE13] ABh plus 24 dummy bits, then one identity byte repeated.
// [RULE14] Identity out from falling edge at bit 0; ends at select rise.
// [RULE15] Pause on hold fall with clock low, resume on hold rise.
// [RULE16] Host keeps hold steady while the serial clock is high.
// [RULE17] Pause only with select low; select rise ends pause, resets state.
// [RULE18] While paused, output floats and clock and input are ignored.
// [RULE19] Host waits 100 us before reads, 10 ms before writes.
// [RULE20] Power-on reset blocks writes while power comes up.
// [RULE21] Write commands rejected unless select rises on an 8-clock boundary.
// [RULE22] Status write rejected when its input runs past two bus cycles.
// [RULE23] Busy flag is one during program, erase or status write.
// [RULE24] Writes need the write latch; completion clears the latch.
// [RULE25] Chip erase runs only when the protect level is zero.
// [RULE26] Write enable opcode 06h sets the latch before writes.
// [RULE27] Input on rising, output on falling edge, MSB first.
module sfcs_top import sfcs_pkg::*; #(
    parameter int ADDR_W = 18,
    parameter int FIFO_DEPTH = 32,
    parameter int PROG_CYC = `SFCS_PROG_CYC,
    parameter int ERASE_CYC = `SFCS_ERASE_CYC,
    parameter int SRW_CYC = `SFCS_SRW_CYC,
    parameter int PU_WRITE_CYC = `SFCS_PU_WRITE_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Serial pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_si,
    input wire logic spi_hold_n,
    input wire logic spi_wp_n,
    output logic spi_so_o,
    output logic spi_so_oe,
    // Status
    output logic status_busy,
    output logic status_write_latch,
    output logic protect_level_bit_low,
    output logic protect_level_bit_high,
    output logic status_lock_bit,
    output logic write_unlocked,
    // Array inspection
    input wire logic [ADDR_W-1:0] mem_rd_addr,
    output logic [7:0] mem_rd_data
);
    // Front end state
    logic sck_q_reg, sck_q_next, cs_q_reg, cs_q_next, hq_reg, hq_next;
    logic hold_reg, hold_next, so_reg, so_next, oon_reg, oon_next;
    logic [2:0] bit_reg, bit_next;
    logic [3:0] byte_reg, byte_next;
    logic [7:0] sh_reg, sh_next, osh_reg, osh_next, cmd_reg, cmd_next;
    logic [7:0] off_reg, off_next, srd_reg, srd_next;
    logic [23:0] addr_reg, addr_next;
    logic [1:0] idx_reg, idx_next;
    logic pend_reg, pend_next;
    logic [15:0] pdat_reg, pdat_next;
    // Engine state
    sfcs_state_t state_reg, state_next;
    logic [31:0] tmr_reg, tmr_next, pu_reg, pu_next;
    logic [ADDR_W-1:0] sw_reg, sw_next;
    logic [ADDR_W-9:0] page_reg, page_next;
    logic [255:0] dirty_reg, dirty_next;
    logic [1:0] prot_reg, prot_next;
    logic wel_reg, wel_next, busy_reg, busy_next, lock_reg, lock_next;
    logic pu_reg_done, pu_done_next, commit_reg, commit_next;
    // Wires
    logic sck_rise, sck_fall, cs_rise, id_phase, aligned, wr_ok;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready, pop;
    logic [15:0] fifo_out_data;
    logic [7:0] rx_byte;
    logic [7:0] pbuf [0:255];
    logic [7:0] cells [0:(1<<ADDR_W)-1];

    // Identity byte for the current output position
    function automatic logic [7:0] sfcs_id_byte(input logic [7:0] cmd,
                                                input logic [1:0] idx);
        if (cmd == `SFCS_OP_ID_SHORT)
            return `SFCS_ID_SHORT;
        unique case (idx)
            2'h0: return `SFCS_ID_MAKER;
            2'h1: return `SFCS_ID_TYPE;
            2'h2: return `SFCS_ID_CAP;
            2'h3: return `SFCS_ID_RSVD;
        endcase
    endfunction : sfcs_id_byte

    // Protected area test on the top two address bits
    function automatic logic sfcs_locked(input logic [1:0] lvl,
                                         input logic [1:0] top);
        unique case (lvl)
            2'h0: return 1'b0;
            2'h1: return top == 2'h3;
            2'h2: return top[1];
            2'h3: return 1'b1;
        endcase
    endfunction : sfcs_locked

    ////////////////////////////////////////////////////////////////////
    // Pin edges and status outputs
    assign sck_rise = spi_sck && !sck_q_reg;
    assign sck_fall = !spi_sck && sck_q_reg;
    assign cs_rise = spi_cs_n && !cs_q_reg;
    assign rx_byte = {sh_reg[6:0], spi_si};
    assign aligned = bit_reg == 3'h0;
    assign spi_so_o = so_reg;
    assign spi_so_oe = !spi_cs_n && !hold_reg && oon_reg; // [RULE18]
    assign status_busy = busy_reg; // [RULE23]
    assign status_write_latch = wel_reg;
    assign protect_level_bit_low = prot_reg[0];
    assign protect_level_bit_high = prot_reg[1];
    assign status_lock_bit = lock_reg;
    assign write_unlocked = pu_reg_done;
    // Identity output phase, suppressed while busy
    assign id_phase = !busy_reg && // [RULE11]
        ((cmd_reg == `SFCS_OP_ID_LONG && // [RULE12]
          byte_reg >= `SFCS_ID_LONG_START) ||
         (cmd_reg == `SFCS_OP_ID_SHORT && // [RULE13]
          byte_reg >= `SFCS_ID_SHORT_START));

    // Serial front end next state
    always_comb
    begin
        sck_q_next = spi_sck;
        cs_q_next = spi_cs_n;
        hq_next = spi_hold_n;
        hold_next = hold_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        sh_next = sh_reg;
        osh_next = osh_reg;
        cmd_next = cmd_reg;
        addr_next = addr_reg;
        off_next = off_reg;
        srd_next = srd_reg;
        so_next = so_reg;
        oon_next = oon_reg;
        idx_next = idx_reg;
        pend_next = pend_reg && !fifo_in_ready;
        pdat_next = pdat_reg;
        if (spi_cs_n)
        begin
            // Deselect clears pause and framing
            hold_next = 1'b0; // [RULE17]
            bit_next = 3'h0;
            byte_next = 4'h0;
            oon_next = 1'b0; // [RULE14]
            idx_next = 2'h0;
        end
        else
        begin
            if (!spi_hold_n && hq_reg && !spi_sck)
                hold_next = 1'b1; // [RULE15]
            else if (spi_hold_n && !hq_reg)
                hold_next = 1'b0; // [RULE15]
            if (!hold_reg && sck_rise)
            begin
                bit_next = bit_reg + 3'h1;
                sh_next = rx_byte; // [RULE27]
                if (bit_reg == 3'h7)
                begin
                    if (byte_reg != `SFCS_BYTE_MAX)
                        byte_next = byte_reg + 4'h1;
                    if (byte_reg == 4'h0)
                        cmd_next = rx_byte;
                    else if (cmd_reg == `SFCS_OP_PAGE_PROG)
                    begin
                        if (byte_reg < `SFCS_DATA_FIRST)
                        begin
                            addr_next = {addr_reg[15:0], rx_byte}; // [RULE5]
                            if (byte_reg == `SFCS_ADDR_LAST)
                                off_next = rx_byte; // [RULE5]
                        end
                        else if (!busy_reg)
                        begin
                            pend_next = 1'b1; // [RULE6]
                            pdat_next = {off_reg, rx_byte};
                            off_next = off_reg + 8'h01; // [RULE7]
                        end
                    end
                    else if (cmd_reg == `SFCS_OP_STATUS_WR &&
                             byte_reg == `SFCS_ONE_BYTE_LEN)
                        srd_next = rx_byte;
                end
            end
            if (!hold_reg && sck_fall)
            begin
                if (aligned && id_phase)
                begin
                    // Load next identity byte, MSB out first
                    {so_next, osh_next} = // [RULE14]
                        {sfcs_id_byte(cmd_reg, idx_reg), 1'b0};
                    oon_next = 1'b1;
                    idx_next = idx_reg + 2'h1; // [RULE12]
                end
                else
                begin
                    so_next = osh_reg[7]; // [RULE27]
                    osh_next = {osh_reg[6:0], 1'b0};
                end
            end
        end
    end

    // Serial front end registers
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sck_q_reg <= 1'b0;
            cs_q_reg <= 1'b1;
            hq_reg <= 1'b1;
            hold_reg <= 1'b0;
            bit_reg <= 3'h0;
            byte_reg <= 4'h0;
            sh_reg <= 8'h00;
            osh_reg <= 8'h00;
            cmd_reg <= 8'h00;
            addr_reg <= 24'h000000;
            off_reg <= 8'h00;
            srd_reg <= 8'h00;
            so_reg <= 1'b0;
            oon_reg <= 1'b0;
            idx_reg <= 2'h0;
            pend_reg <= 1'b0;
            pdat_reg <= 16'h0000;
        end
        else
        begin
            sck_q_reg <= sck_q_next;
            cs_q_reg <= cs_q_next;
            hq_reg <= hq_next;
            hold_reg <= hold_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            sh_reg <= sh_next;
            osh_reg <= osh_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            off_reg <= off_next;
            srd_reg <= srd_next;
            so_reg <= so_next;
            oon_reg <= oon_next;
            idx_reg <= idx_next;
            pend_reg <= pend_next;
            pdat_reg <= pdat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Program byte queue; drains only while the page buffer is free
    assign fifo_out_ready = state_reg == ST_IDLE || state_reg == ST_DRAIN;
    assign pop = fifo_out_valid && fifo_out_ready;

    sfcs_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(pend_reg),
        .in_ready(fifo_in_ready),
        .in_data(pdat_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Write engine next state
    assign wr_ok = wel_reg && pu_reg_done && !busy_reg; // [RULE24] [RULE20]

    always_comb
    begin
        state_next = state_reg;
        tmr_next = tmr_reg;
        sw_next = sw_reg;
        page_next = page_reg;
        dirty_next = dirty_reg;
        prot_next = prot_reg;
        lock_next = lock_reg;
        wel_next = wel_reg;
        commit_next = commit_reg;
        pu_next = pu_reg;
        pu_done_next = pu_reg_done;
        if (!pu_reg_done)
        begin
            // Write lockout after power-on
            pu_next = pu_reg + 32'h1; // [RULE20]
            pu_done_next = pu_reg >= 32'(PU_WRITE_CYC - 1);
        end
        if (pop)
            dirty_next[fifo_out_data[15:8]] = 1'b1; // [RULE7]
        unique case (state_reg)
            ST_IDLE:
            begin
                if (cs_rise && aligned) // [RULE21]
                begin
                    if (cmd_reg == `SFCS_OP_WREN &&
                        byte_reg == `SFCS_ONE_BYTE_LEN)
                        wel_next = 1'b1; // [RULE26]
                    else if (cmd_reg == `SFCS_OP_WRDI &&
                             byte_reg == `SFCS_ONE_BYTE_LEN)
                        wel_next = 1'b0;
                    else if (cmd_reg == `SFCS_OP_CHIP_ERASE &&
                             byte_reg == `SFCS_ONE_BYTE_LEN && // [RULE1]
                             wr_ok && prot_reg == 2'h0) // [RULE25]
                    begin
                        state_next = ST_ESWEEP; // [RULE2]
                        sw_next = '0;
                    end
                    else if (cmd_reg == `SFCS_OP_STATUS_WR &&
                             byte_reg == `SFCS_SRW_LEN && wr_ok && // [RULE22]
                             !(lock_reg && !spi_wp_n))
                    begin
                        prot_next = srd_reg[3:2];
                        lock_next = srd_reg[7];
                        state_next = ST_WAIT;
                        tmr_next = 32'(SRW_CYC);
                    end
                end
                if (cs_rise && cmd_reg == `SFCS_OP_PAGE_PROG)
                begin
                    // Judge the frame, then let the queue empty
                    commit_next = aligned && wr_ok && // [RULE8]
                        byte_reg >= `SFCS_PP_MIN_LEN && // [RULE4]
                        !sfcs_locked(prot_reg, addr_reg[ADDR_W-1:ADDR_W-2]);
                    page_next = addr_reg[ADDR_W-1:8]; // [RULE4]
                    state_next = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                if (!fifo_out_valid && !pend_reg)
                begin
                    sw_next = '0;
                    if (commit_reg)
                        state_next = ST_PSWEEP;
                    else
                    begin
                        state_next = ST_IDLE;
                        dirty_next = '0;
                    end
                end
            end
            ST_PSWEEP:
            begin
                sw_next = sw_reg + 1'b1;
                if (sw_reg[7:0] == 8'hff)
                begin
                    dirty_next = '0;
                    commit_next = 1'b0;
                    state_next = ST_WAIT;
                    tmr_next = 32'(PROG_CYC); // [RULE10]
                end
            end
            ST_ESWEEP:
            begin
                sw_next = sw_reg + 1'b1;
                if (&sw_reg)
                begin
                    state_next = ST_WAIT;
                    tmr_next = 32'(ERASE_CYC); // [RULE2]
                end
            end
            ST_WAIT:
            begin
                tmr_next = tmr_reg - 32'h1;
                if (tmr_reg <= 32'h1)
                begin
                    state_next = ST_IDLE;
                    wel_next = 1'b0; // [RULE24]
                end
            end
            default:
                state_next = ST_IDLE;
        endcase
        busy_next = state_next != ST_IDLE && // [RULE23]
            !(state_next == ST_DRAIN && !commit_next);
    end

    // Write engine registers
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_IDLE;
            tmr_reg <= 32'h0;
            sw_reg <= '0;
            page_reg <= '0;
            dirty_reg <= '0;
            prot_reg <= `SFCS_PROT_RST;
            lock_reg <= `SFCS_LOCK_RST;
            wel_reg <= 1'b0;
            busy_reg <= 1'b0;
            commit_reg <= 1'b0;
            pu_reg <= 32'h0;
            pu_reg_done <= 1'b0;
            mem_rd_data <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            sw_reg <= sw_next;
            page_reg <= page_next;
            dirty_reg <= dirty_next;
            prot_reg <= prot_next;
            lock_reg <= lock_next;
            wel_reg <= wel_next;
            busy_reg <= busy_next;
            commit_reg <= commit_next;
            pu_reg <= pu_next;
            pu_reg_done <= pu_done_next;
            mem_rd_data <= cells[mem_rd_addr];
        end
    end

    // Page buffer load and cell array updates
    always_ff @(posedge clock)
    begin
        if (pop)
            pbuf[fifo_out_data[15:8]] <= fifo_out_data[7:0]; // [RULE6]
        if (state_reg == ST_ESWEEP)
            cells[sw_reg] <= `SFCS_ERASED_BYTE; // [RULE3]
        else if (state_reg == ST_PSWEEP && dirty_reg[sw_reg[7:0]])
            cells[{page_reg, sw_reg[7:0]}] <= // [RULE4]
                cells[{page_reg, sw_reg[7:0]}] & pbuf[sw_reg[7:0]];
    end
endmodule : sfcs_top

// ### sfcs_consts.svh
`ifndef SFCS_CONSTS_SVH
`define SFCS_CONSTS_SVH
// Opcodes
`define SFCS_OP_WREN 8'h06
`define SFCS_OP_WRDI 8'h04
`define SFCS_OP_CHIP_ERASE 8'hc7
`define SFCS_OP_PAGE_PROG 8'h92
`define SFCS_OP_ID_LONG 8'h9f
`define SFCS_OP_ID_SHORT 8'hab
`define SFCS_OP_STATUS_WR 8'h01
// Identity bytes, values arbitrary
`define SFCS_ID_MAKER 8'h5a
`define SFCS_ID_TYPE 8'h11
`define SFCS_ID_CAP 8'h12
`define SFCS_ID_RSVD 8'h00
`define SFCS_ID_SHORT 8'h3c
// Bus cycle positions
`define SFCS_BYTE_MAX 4'hf
`define SFCS_ADDR_LAST 4'h3
`define SFCS_DATA_FIRST 4'h4
`define SFCS_PP_MIN_LEN 4'h5
`define SFCS_ID_LONG_START 4'h1
`define SFCS_ID_SHORT_START 4'h4
`define SFCS_ONE_BYTE_LEN 4'h1
`define SFCS_SRW_LEN 4'h2
// Cell and status values
`define SFCS_ERASED_BYTE 8'hff
`define SFCS_PROT_RST 2'h0
`define SFCS_LOCK_RST 1'b0
// Timing
`define SFCS_CLK_MHZ 40
`define SFCS_PROG_US 2000
`define SFCS_PROG_CYC (`SFCS_PROG_US * `SFCS_CLK_MHZ)
`define SFCS_ERASE_US 250000
`define SFCS_ERASE_CYC (`SFCS_ERASE_US * `SFCS_CLK_MHZ)
`define SFCS_SRW_US 5000
`define SFCS_SRW_CYC (`SFCS_SRW_US * `SFCS_CLK_MHZ)
`define SFCS_PU_WRITE_US 10000
`define SFCS_PU_WRITE_CYC (`SFCS_PU_WRITE_US * `SFCS_CLK_MHZ)
`endif

// ### sfcs_pkg.sv
package sfcs_pkg;
    // Write engine states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DRAIN = 5'b00010,
        ST_PSWEEP = 5'b00100,
        ST_ESWEEP = 5'b01000,
        ST_WAIT = 5'b10000
    } sfcs_state_t;
endpackage : sfcs_pkg

// ### sfcs_asserts.sv
`timescale 1ns/1ps
module sfcs_asserts #(
    parameter int ADDR_W = 18
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Serial pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_si,
    input wire logic spi_hold_n,
    input wire logic spi_wp_n,
    input wire logic spi_so_o,
    input wire logic spi_so_oe,
    // Status
    input wire logic status_busy,
    input wire logic status_write_latch,
    input wire logic protect_level_bit_low,
    input wire logic protect_level_bit_high,
    input wire logic status_lock_bit,
    input wire logic write_unlocked,
    // Array inspection
    input wire logic [ADDR_W-1:0] mem_rd_addr,
    input wire logic [7:0] mem_rd_data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////
    // Write engine, output driver and lockout relations
    property p_cause;
        $rose(status_busy) |-> $past(spi_cs_n)
            && (!$past(spi_cs_n, 2) || !$past(spi_cs_n, 3));
    endproperty
    a_cause: assert property (p_cause)
        else $error("busy without select rise");
    property p_gate;
        $rose(status_busy) |-> $past(write_unlocked && status_write_latch);
    endproperty
    a_gate: assert property (p_gate)
        else $error("write started while locked");
    property p_clr; $fell(status_busy) |-> !status_write_latch; endproperty
    a_clr: assert property (p_clr)
        else $error("latch kept after write");
    property p_oe_cs; (spi_cs_n || $fell(spi_cs_n)) |-> !spi_so_oe; endproperty
    a_oe_cs: assert property (p_oe_cs)
        else $error("output driven while deselected");
    property p_no_id; status_busy |-> !$rose(spi_so_oe); endproperty
    a_no_id: assert property (p_no_id)
        else $error("identity output while busy");
    property p_hold; !spi_hold_n [*3] |-> !spi_so_oe; endproperty
    a_hold: assert property (p_hold)
        else $error("output driven while paused");
    property p_edge;
        spi_so_oe && $past(spi_so_oe) && $changed(spi_so_o)
            |-> !$past(spi_sck) || !$past(spi_sck, 2);
    endproperty
    a_edge: assert property (p_edge)
        else $error("output moved without clock fall");
    property p_unl; write_unlocked |=> write_unlocked; endproperty
    a_unl: assert property (p_unl)
        else $error("write lockout returned");
    c_busy: cover property ($rose(status_busy));
    c_id: cover property ($rose(spi_so_oe));
    c_pause: cover property ($fell(spi_hold_n) && !spi_cs_n);
endmodule : sfcs_asserts

// ### sfcs_host.sv
`timescale 1ns/1ps
module sfcs_host (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    logic [7:0] tx [300];
    logic [7:0] rx [300];
    logic saw_oe;
    int hold_at = -1;
    // Idle lines, select high from power-on
    initial
    begin
        cs_n = 1;
        sck = 0;
        si = 0;
        hold_n = 1;
        foreach (tx[j]) tx[j] = 8'h00;
    end
    // One select frame, MSB first, optional pause
    task frame(input int nbits);
        saw_oe = 0;
        @(negedge clock) cs_n = 0;
        for (int i = 0; i < nbits; i++)
        begin
            si = tx[i/8][7-i%8];
            repeat (3) @(negedge clock);
            if (i == hold_at)
            begin
                hold_n = 0;
                si = ~si;
                repeat (2) @(negedge clock) sck = ~sck;
                repeat (2) @(negedge clock);
                si = ~si;
                hold_n = 1;
                repeat (2) @(negedge clock);
            end
            sck = 1;
            rx[i/8][7-i%8] = so;
            saw_oe |= so_oe;
            repeat (2) @(negedge clock);
            sck = 0;
        end
        @(negedge clock) cs_n = 1;
        si = ~si; // Stale bit must not look held
        repeat (2) @(negedge clock);
    endtask : frame
endmodule : sfcs_host

// ### tb.sv
`timescale 1ns/1ps
`include "sfcs_consts.svh"
module tb;
    typedef struct {
        logic [7:0] op;
        int hold;
        logic [3:0][7:0] exp;
    } sfcs_row_t;
    logic clock, arst_n, spi_cs_n, spi_sck, spi_si, spi_hold_n, spi_wp_n;
    logic spi_so_o, spi_so_oe, status_busy, status_write_latch, write_unlocked;
    logic protect_level_bit_low, protect_level_bit_high, status_lock_bit;
    logic [9:0] mem_rd_addr;
    logic [7:0] mem_rd_data;
    wire [7:0] busy_wel = {6'h0, status_busy, status_write_latch};
    wire [7:0] busy_prot = {6'h0, status_busy, protect_level_bit_low};
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    sfcs_row_t rows [3] = '{
        '{`SFCS_OP_ID_LONG, -1, {`SFCS_ID_MAKER, `SFCS_ID_TYPE,
            `SFCS_ID_CAP, `SFCS_ID_RSVD}},
        '{`SFCS_OP_ID_SHORT, -1, {4{`SFCS_ID_SHORT}}},
        '{`SFCS_OP_ID_LONG, 12, {`SFCS_ID_MAKER, `SFCS_ID_TYPE,
            `SFCS_ID_CAP, `SFCS_ID_RSVD}}};
    sfcs_host host (
        .clock(clock),
        .cs_n(spi_cs_n),
        .sck(spi_sck),
        .si(spi_si),
        .hold_n(spi_hold_n),
        .so(spi_so_o),
        .so_oe(spi_so_oe)
    );
    sfcs_top #(.ADDR_W(10), .PROG_CYC(20), .ERASE_CYC(50), .SRW_CYC(20),
        .PU_WRITE_CYC(150)) uut (.*);
    ////////////////////////////////////////////////////////////
    // Helpers
    task check(input string nm, input logic [7:0] got, input logic [7:0] e);
        num_checks++;
        if (got !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, got);
        end
    endtask : check
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task cmd(input logic [31:0] b, input int nbits);
        for (int j = 0; j < 4; j++) host.tx[j] = b[31-8*j -: 8];
        host.frame(nbits);
    endtask : cmd
    task chk_mem(input logic [9:0] a, input logic [7:0] e);
        mem_rd_addr = a;
        @(negedge clock);
        check("cell", mem_rd_data, e);
    endtask : chk_mem
    task wait_idle(input int lim);
        n = 0;
        while (status_busy !== 1'b0)
        begin
            @(negedge clock);
            n++;
            if (n > lim)
            begin
                error_cnt++;
                give_verdict;
            end
        end
    endtask : wait_idle
    function automatic logic [7:0] dat(input int k);
        return 8'(k) ^ (k > 255 ? 8'h80 : 8'h00);
    endfunction : dat
    ////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    // Main sequence
    initial
    begin
        arst_n = 0;
        spi_wp_n = 1;
        repeat (20) @(negedge clock);
        arst_n = 1;
        @(negedge clock);
        cmd(32'h06000000, 8);
        cmd(32'hc7000000, 8);
        check("early", 8'(status_busy), 8'h0);
        foreach (rows[r])
        begin
            n = (rows[r].op == `SFCS_OP_ID_SHORT) ? 4 : 1;
            host.tx[0] = rows[r].op;
            host.hold_at = rows[r].hold;
            host.frame((n + 8) * 8);
            for (int j = 0; j < 8; j++)
                check("id", host.rx[n+j], rows[r].exp[3-j%4]);
        end
        host.hold_at = -1;
        check("unlock", 8'(write_unlocked), 8'h1);
        cmd(32'h06000000, 8);
        cmd(32'hc7000000, 12);
        cmd(32'hc7000000, 16);
        check("bad erase", busy_wel, 8'h1);
        cmd(32'hc7000000, 8);
        check("erase", 8'(status_busy), 8'h1);
        cmd(32'h9f000000, 24);
        check("busy id", 8'(host.saw_oe), 8'h0);
        wait_idle(3000);
        check("latch", 8'(status_write_latch), 8'h0);
        for (int a = 0; a < 1024; a++) chk_mem(a[9:0], 8'hff);
        cmd(32'h06000000, 8);
        cmd(32'h01040000, 24);
        check("long srw", busy_prot, 8'h0);
        cmd(32'h01040000, 16);
        wait_idle(500);
        cmd(32'h06000000, 8);
        cmd(32'hc7000000, 8);
        check("prot", busy_prot, 8'h1);
        cmd(32'h01000000, 16);
        wait_idle(500);
        cmd(32'h06000000, 8);
        for (int k = 0; k < 258; k++) host.tx[4+k] = dat(k);
        cmd(32'h920001f0, 262 * 8);
        wait_idle(1000);
        check("prog time", 8'(n > 270), 8'h1);
        check("latch", 8'(status_write_latch), 8'h0);
        for (int o = 0; o < 256; o++)
        begin
            n = (o + 14) % 256 + 2; // Index of the last byte sent here
            chk_mem(10'h100 + o[9:0], dat(n));
        end
        chk_mem(10'h0ff, 8'hff);
        chk_mem(10'h200, 8'hff);
        cmd(32'h06000000, 8);
        cmd(32'h92000000, 43);
        check("part", {6'h0, status_busy, status_write_latch}, 8'h1);
        chk_mem(10'h000, 8'hff);
        give_verdict;
    end
endmodule : tb
bind sfcs_top sfcs_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);
